// ==== include/fifo_event_pkg.sv ====
// Shared constants for the FIFO and waveform-engine autovector block.
package fifo_event_pkg;

  localparam int NUM_SOURCES = 14;
  localparam int INDEX_W = 4;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] SETUP_OFFSET = 12'h000;
  localparam logic [11:0] ENABLE_OFFSET = 12'h004;
  localparam logic [11:0] PENDING_OFFSET = 12'h008;
  localparam logic [11:0] VECTOR_OFFSET = 12'h00c;

  localparam int AUTOVECTOR_BIT = 0;
  localparam logic [13:0] ENABLE_RESET = 14'h0000;
  localparam logic [13:0] PENDING_RESET = 14'h0000;
  localparam logic SETUP_RESET = 1'b0;

  // Source order by priority; index 0 is served first.
  localparam int SRC_LEVEL_BASE = 0;
  localparam int SRC_EMPTY_BASE = 4;
  localparam int SRC_FULL_BASE = 8;
  localparam int SRC_COMPLETE = 12;
  localparam int SRC_WAVEFORM = 13;

  localparam logic [13:0][7:0] VECTOR_TABLE = {
    8'hb4, 8'hb0,
    8'hac, 8'ha8, 8'ha4, 8'ha0,
    8'h9c, 8'h98, 8'h94, 8'h90,
    8'h8c, 8'h88, 8'h84, 8'h80
  };

  // Code addresses of the jump slot fetched by the processor.
  localparam logic [15:0] ENTRY_ADDR = 16'h0053;
  localparam logic [15:0] PAGE_ADDR = 16'h0054;
  localparam logic [15:0] VECTOR_ADDR = 16'h0055;

  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ACCESS = 1'b1
  } apb_state_t;

endpackage : fifo_event_pkg

// ==== rtl/fifo_event_priority.sv ====
// Fixed-priority selector that maps the winning source to its vector byte.
`timescale 1ns/1ps
module fifo_event_priority (
  input wire logic [fifo_event_pkg::NUM_SOURCES-1:0] active,
  output logic any_active,
  output logic [fifo_event_pkg::INDEX_W-1:0] win_index,
  output logic [7:0] win_vector
);
  import fifo_event_pkg::*;

  // Lowest index wins, so the loop runs downward and the last hit stands.
  always_comb begin
    any_active = 1'b0;
    win_index = '0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (active[i]) begin
        any_active = 1'b1;
        win_index = INDEX_W'(i);
      end
    end
    win_vector = VECTOR_TABLE[win_index];
  end

endmodule : fifo_event_priority

// ==== rtl/fifo_event_autovector.sv ====
// Second-level vectoring for the FIFO and waveform-engine interrupt line.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fifo_event_autovector (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic endpoint_two_level_flag,
  input wire logic endpoint_four_level_flag,
  input wire logic endpoint_six_level_flag,
  input wire logic endpoint_eight_level_flag,
  input wire logic endpoint_two_empty,
  input wire logic endpoint_four_empty,
  input wire logic endpoint_six_empty,
  input wire logic endpoint_eight_empty,
  input wire logic endpoint_two_full,
  input wire logic endpoint_four_full,
  input wire logic endpoint_six_full,
  input wire logic endpoint_eight_full,
  input wire logic waveform_engine_complete,
  input wire logic waveform_engine_waveform_event,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] fetch_mem_byte,
  output logic [7:0] fetch_byte,
  output logic fetch_done,
  output logic [15:0] entry_addr,
  output logic fifo_event_interrupt_line
);
  import fifo_event_pkg::*;

  logic [NUM_SOURCES-1:0] src;
  logic [NUM_SOURCES-1:0] src_prev_reg, src_prev_next;
  logic [NUM_SOURCES-1:0] pending_reg, pending_next;
  logic [NUM_SOURCES-1:0] enable_reg, enable_next;
  logic fifo_autovector_enable_reg, fifo_autovector_enable_next;
  apb_state_t apb_state_reg, apb_state_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] fetch_byte_reg, fetch_byte_next;
  logic fetch_done_reg, fetch_done_next;
  logic line_reg, line_next;
  logic [NUM_SOURCES-1:0] active;
  logic any_active;
  logic [INDEX_W-1:0] win_index;
  logic [7:0] fifo_event_vector_byte;
  logic wr_fire;

  assign src = {waveform_engine_waveform_event, waveform_engine_complete,
                endpoint_eight_full, endpoint_six_full, endpoint_four_full, endpoint_two_full,
                endpoint_eight_empty, endpoint_six_empty, endpoint_four_empty, endpoint_two_empty,
                endpoint_eight_level_flag, endpoint_six_level_flag,
                endpoint_four_level_flag, endpoint_two_level_flag};

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == SETUP_OFFSET) || (addr == ENABLE_OFFSET) ||
                (addr == PENDING_OFFSET) || (addr == VECTOR_OFFSET);
  endfunction : is_mapped

  assign active = pending_reg & enable_reg;
  assign wr_fire = psel && penable && pready && pwrite && is_mapped(paddr);

  fifo_event_priority u_priority (
    .active(active),
    .any_active(any_active),
    .win_index(win_index),
    .win_vector(fifo_event_vector_byte)
  );

  // The read word is captured in the setup cycle, so the access phase is always one cycle.
  always_comb begin
    apb_state_next = APB_IDLE;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      apb_state_next = APB_ACCESS;
      pslverr_next = !is_mapped(paddr);
      prdata_next = '0;
      case (paddr)
        SETUP_OFFSET: prdata_next[AUTOVECTOR_BIT] = fifo_autovector_enable_reg;
        ENABLE_OFFSET: prdata_next[NUM_SOURCES-1:0] = enable_reg;
        PENDING_OFFSET: prdata_next[NUM_SOURCES-1:0] = pending_reg;
        VECTOR_OFFSET: prdata_next[7:0] = fifo_event_vector_byte;
        default: prdata_next = '0;
      endcase
    end
  end

  // A new edge on a source beats a write-one-to-clear in the same cycle.
  always_comb begin
    src_prev_next = src;
    pending_next = pending_reg;
    enable_next = enable_reg;
    fifo_autovector_enable_next = fifo_autovector_enable_reg;
    if (wr_fire) begin
      case (paddr)
        SETUP_OFFSET: fifo_autovector_enable_next = pwdata[AUTOVECTOR_BIT];
        ENABLE_OFFSET: enable_next = pwdata[NUM_SOURCES-1:0];
        PENDING_OFFSET: pending_next = pending_reg & ~pwdata[NUM_SOURCES-1:0];
        default: pending_next = pending_reg;
      endcase
    end
    pending_next = pending_next | (src & ~src_prev_reg);
    line_next = |(pending_next & enable_next);
  end

  // Code fetch path; the returned byte is registered, one cycle behind the request.
  always_comb begin
    fetch_done_next = fetch_valid;
    fetch_byte_next = fetch_byte_reg;
    if (fetch_valid) begin
      fetch_byte_next = fetch_mem_byte;
      if (fetch_addr == VECTOR_ADDR && fifo_autovector_enable_reg && any_active) begin
        fetch_byte_next = fifo_event_vector_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= APB_IDLE;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      apb_state_reg <= apb_state_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= '0;
      pending_reg <= PENDING_RESET;
      enable_reg <= ENABLE_RESET;
      fifo_autovector_enable_reg <= SETUP_RESET;
      line_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
      pending_reg <= pending_next;
      enable_reg <= enable_next;
      fifo_autovector_enable_reg <= fifo_autovector_enable_next;
      line_reg <= line_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_byte_reg <= '0;
      fetch_done_reg <= 1'b0;
    end else begin
      fetch_byte_reg <= fetch_byte_next;
      fetch_done_reg <= fetch_done_next;
    end
  end

  assign pready = (apb_state_reg == APB_ACCESS);
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && pready;
  assign fetch_byte = fetch_byte_reg;
  assign fetch_done = fetch_done_reg;
  assign entry_addr = ENTRY_ADDR;
  assign fifo_event_interrupt_line = line_reg;

  irq_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_event_interrupt_line == |active)
    else $error("interrupt line does not match enabled pending sources");

  level_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_LEVEL_BASE + 3] && active[2:0] == 3'b000 |-> fifo_event_vector_byte == 8'h8c)
    else $error("eighth endpoint level flag vector wrong");

  empty_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_EMPTY_BASE] && active[3:0] == 4'h0 |-> fifo_event_vector_byte == 8'h90)
    else $error("second endpoint empty vector wrong");

  full_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_FULL_BASE + 2] && active[9:0] == 10'h000 |-> fifo_event_vector_byte == 8'ha8)
    else $error("sixth endpoint full vector wrong");

  wave_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_WAVEFORM] && active[0] |-> fifo_event_vector_byte == 8'h80)
    else $error("priority one did not win over waveform event");

  wave_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    active == 14'h2000 |-> fifo_event_vector_byte == 8'hb4)
    else $error("waveform event vector wrong");

  vector_subst_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr == VECTOR_ADDR && fifo_autovector_enable_reg && any_active
    |=> fetch_done && fetch_byte == $past(fifo_event_vector_byte))
    else $error("vector byte not substituted");

  page_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr == PAGE_ADDR |=> fetch_byte == $past(fetch_mem_byte))
    else $error("page byte altered");

  entry_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    entry_addr == 16'h0053)
    else $error("service entry address wrong");

  plain_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && !fifo_autovector_enable_reg |=> fetch_byte == $past(fetch_mem_byte))
    else $error("fetch altered while autovectoring is off");

  masked_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_active |-> active[win_index] && pending_reg[win_index] && enable_reg[win_index])
    else $error("winner is not an enabled pending source");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    src[0] && !src_prev_reg[0] |=> pending_reg[0])
    else $error("source edge lost against clear");

  level_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_LEVEL_BASE] |-> fifo_event_vector_byte == 8'h80)
    else $error("second endpoint level flag vector wrong");

  level_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[1] && !active[0] |-> fifo_event_vector_byte == 8'h84)
    else $error("fourth endpoint level flag vector wrong");

  level_six_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[2] && active[1:0] == 2'b00 |-> fifo_event_vector_byte == 8'h88)
    else $error("sixth endpoint level flag vector wrong");

  empty_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[5] && active[4:0] == 5'h00 |-> fifo_event_vector_byte == 8'h94)
    else $error("fourth endpoint empty vector wrong");

  empty_six_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[6] && active[5:0] == 6'h00 |-> fifo_event_vector_byte == 8'h98)
    else $error("sixth endpoint empty vector wrong");

  empty_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[7] && active[6:0] == 7'h00 |-> fifo_event_vector_byte == 8'h9c)
    else $error("eighth endpoint empty vector wrong");

  full_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[8] && active[7:0] == 8'h00 |-> fifo_event_vector_byte == 8'ha0)
    else $error("second endpoint full vector wrong");

  full_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[9] && active[8:0] == 9'h000 |-> fifo_event_vector_byte == 8'ha4)
    else $error("fourth endpoint full vector wrong");

  full_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[11] && active[10:0] == 11'h000 |-> fifo_event_vector_byte == 8'hac)
    else $error("eighth endpoint full vector wrong");

  complete_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    active[SRC_COMPLETE] && active[11:0] == 12'h000 |-> fifo_event_vector_byte == 8'hb0)
    else $error("operation complete vector wrong");

  fetch_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_done == $past(fetch_valid))
    else $error("fetch answer not one cycle after request");

  idle_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr == VECTOR_ADDR && !any_active |=> fetch_byte == $past(fetch_mem_byte))
    else $error("vector slot altered with no source active");

  other_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr != VECTOR_ADDR |=> fetch_byte == $past(fetch_mem_byte))
    else $error("byte outside the vector slot altered");

  enable_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    enable_reg == 14'h0000 |-> !fifo_event_interrupt_line)
    else $error("interrupt line raised with every source disabled");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == ENABLE_OFFSET |=> enable_reg == $past(pwdata[NUM_SOURCES-1:0]))
    else $error("source enables not written");

  setup_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == SETUP_OFFSET |=> fifo_autovector_enable_reg == $past(pwdata[AUTOVECTOR_BIT]))
    else $error("autovector enable not written");

  clear_pending_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == PENDING_OFFSET && pwdata[0] && !(src[0] && !src_prev_reg[0])
    |=> !pending_reg[0])
    else $error("pending bit not cleared by write");

  subst_c: cover property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr == VECTOR_ADDR && fifo_autovector_enable_reg && any_active);
  clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == PENDING_OFFSET && pending_reg != 14'h0000);
  two_src_c: cover property (@(posedge pclk) disable iff (!presetn)
    active[SRC_COMPLETE] && active[SRC_EMPTY_BASE + 1]);
  slverr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  plain_fetch_c: cover property (@(posedge pclk) disable iff (!presetn)
    fetch_valid && fetch_addr == VECTOR_ADDR && !fifo_autovector_enable_reg);

endmodule : fifo_event_autovector

// ==== verif/core_fetch_model.sv ====
// Behavioural processor core that fetches the three bytes of the interrupt jump slot.
`timescale 1ns/1ps
module core_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] entry_addr,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic [7:0] fetch_mem_byte
);
  import fifo_event_pkg::*;
  logic [1:0] left_reg;
  logic [15:0] next_addr;
  // Service starts at the entry address and walks the jump instruction byte by byte.
  assign next_addr = start ? entry_addr : fetch_addr + 16'h0001;
  // Firmware image keeps the jump table page byte just before the vector slot.
  function automatic logic [7:0] code_byte(input logic [15:0] a);
    return (a == PAGE_ADDR) ? 8'h12 : a[7:0] ^ 8'h3c;
  endfunction : code_byte
  // Between fetches the bus carries inverted junk, so a stale byte never passes for data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_valid <= 1'b0;
      fetch_addr <= 16'h0000;
      fetch_mem_byte <= 8'h00;
      left_reg <= 2'h0;
    end else if (start || left_reg != 2'h0) begin
      fetch_valid <= 1'b1;
      fetch_addr <= next_addr;
      fetch_mem_byte <= code_byte(next_addr);
      left_reg <= start ? 2'h2 : left_reg - 2'h1;
    end else begin
      fetch_valid <= 1'b0;
      fetch_addr <= ~fetch_addr;
      fetch_mem_byte <= ~fetch_mem_byte;
    end
  end
endmodule : core_fetch_model

// ==== verif/fifo_event_autovector_tb.sv ====
// Self-checking testbench for the FIFO event autovector block.
`timescale 1ns/1ps
module fifo_event_autovector_tb;
  import fifo_event_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic start = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] src = 14'h0;
  logic [31:0] prdata;
  logic pready, pslverr, fetch_valid, fetch_done, line;
  logic [15:0] fetch_addr, entry_addr;
  logic [7:0] fetch_mem_byte, fetch_byte;
  logic [32:0] exp_q[$];
  integer fail_count = 0;
  integer check_count = 0;
  integer seed = 32'hacb8;
  logic [31:0] r_en, r_src;
  logic [13:0] act;
  int k, win;

  fifo_event_autovector uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fetch_valid, .fetch_addr, .fetch_mem_byte, .fetch_byte,
    .fetch_done, .entry_addr, .fifo_event_interrupt_line(line),
    .endpoint_two_level_flag(src[0]), .endpoint_four_level_flag(src[1]),
    .endpoint_six_level_flag(src[2]), .endpoint_eight_level_flag(src[3]),
    .endpoint_two_empty(src[4]), .endpoint_four_empty(src[5]),
    .endpoint_six_empty(src[6]), .endpoint_eight_empty(src[7]),
    .endpoint_two_full(src[8]), .endpoint_four_full(src[9]),
    .endpoint_six_full(src[10]), .endpoint_eight_full(src[11]),
    .waveform_engine_complete(src[12]), .waveform_engine_waveform_event(src[13]));
  core_fetch_model core (.pclk, .presetn, .start, .entry_addr, .fetch_valid, .fetch_addr,
    .fetch_mem_byte);

  initial forever #50 pclk = ~pclk;

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task finish_test;
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Results are sampled mid-cycle, where registered outputs have settled.
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
    if (fetch_done) check({25'h0, fetch_byte}, exp_q.pop_front());
  end

  // The request stands until pready is seen high at a rising edge, then it is released.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        finish_test;
      end
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task jump(input logic [7:0] last);
    exp_q.push_back(33'h06f);
    exp_q.push_back(33'h012);
    exp_q.push_back({25'h0, last});
    @(posedge pclk);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : jump

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check({17'h0, entry_addr}, 33'h0053);
    rd(SETUP_OFFSET, 33'h0);
    rd(ENABLE_OFFSET, 33'h0);
    rd(PENDING_OFFSET, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    apb(1'b1, SETUP_OFFSET, 32'h1);
    // Each source alone first, then random mixes where enables decide the winner.
    for (k = 0; k < 22; k++) begin
      r_en = (k < 14) ? 32'h3fff : $random(seed);
      r_src = (k < 14) ? (32'h1 << k) : $random(seed);
      apb(1'b1, ENABLE_OFFSET, r_en & 32'h3fff);
      src <= r_src[13:0];
      act = r_src[13:0] & r_en[13:0];
      win = 14;
      for (int i = 13; i >= 0; i--) if (act[i]) win = i;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check({32'h0, line}, {32'h0, |act});
      rd(PENDING_OFFSET, {19'h0, r_src[13:0]});
      rd(VECTOR_OFFSET, {25'h0, 8'h80 + 8'(4 * (win % 14))});
      jump((win < 14) ? 8'h80 + 8'(4 * win) : 8'h69);
      src <= 14'h0;
      apb(1'b1, PENDING_OFFSET, 32'h3fff);
    end
    apb(1'b1, SETUP_OFFSET, 32'h0);
    apb(1'b1, ENABLE_OFFSET, 32'h3fff);
    src <= 14'h1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({32'h0, line}, 33'h1);
    jump(8'h69);
    // A source edge on the very edge where its clear lands must leave the bit set.
    src <= 14'h0;
    fork
      apb(1'b1, PENDING_OFFSET, 32'h3fff);
      begin
        repeat (2) @(posedge pclk);
        src <= 14'h1;
      end
    join
    rd(PENDING_OFFSET, {19'h0, 14'h1});
    apb(1'b1, 12'h010, 32'h0);
    rd(ENABLE_OFFSET, {19'h0, 14'h3fff});
    // Reset in mid-run with a source held high: its level counts as a new edge.
    presetn <= 1'b0;
    @(negedge pclk);
    check({line, prdata}, 33'h0);
    check({25'h0, fetch_byte}, 33'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(SETUP_OFFSET, 33'h0);
    rd(ENABLE_OFFSET, 33'h0);
    rd(PENDING_OFFSET, {19'h0, 14'h1});
    finish_test;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    finish_test;
  end
endmodule : fifo_event_autovector_tb
